/* bus_master_model.sv */
// Two-wire bus master model driving clock and data toward the write slave
`timescale 1ns/1ps

module bus_master_model #(
  parameter int HALF_NS = 750
) (
  // Wire level
  input  wire logic i_sda,
  // Bus drive
  output logic      o_scl,
  output logic      o_sda_oe
);
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end
  // Data only moves a while after the clock has fallen
  task automatic put_bit(input logic b);
    #(HALF_NS/3) o_sda_oe = !b;
    #HALF_NS o_scl = 1'b1;
    #HALF_NS o_scl = 1'b0;
  endtask
  task automatic start();
    #(HALF_NS/3) o_sda_oe = 1'b0;
    #HALF_NS o_scl = 1'b1;
    #HALF_NS o_sda_oe = 1'b1;
    #HALF_NS o_scl = 1'b0;
  endtask
  task automatic stop();
    #(HALF_NS/3) o_sda_oe = 1'b1;
    #HALF_NS o_scl = 1'b1;
    #HALF_NS o_sda_oe = 1'b0;
    #HALF_NS;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(b[i]);
    #(HALF_NS/3) o_sda_oe = 1'b0;
    #HALF_NS o_scl = 1'b1;
    #(HALF_NS-10) ack = !i_sda;
    #10 o_scl = 1'b0;
  endtask
endmodule

/* eeprom_write_pkg.sv */
// Constants and types shared by the serial EEPROM write front end
package eeprom_write_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int unsigned CLOCK_HZ              = 20_000_000;
  localparam int unsigned PROGRAM_CYCLE_TIME_US = 5000;
  localparam int unsigned PROGRAM_CYCLES        = PROGRAM_CYCLE_TIME_US * (CLOCK_HZ / 1_000_000);

  // ------------------------------------------------------------------
  // Address and page layout
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_BITS  = 16;
  localparam int unsigned PAGE_BITS  = 7;
  localparam int unsigned PAGE_BYTES = 128;
  localparam int unsigned DATA_BITS  = 8;
  localparam logic [6:0]  PAGE_LAST  = 7'h7F;

  // ------------------------------------------------------------------
  // Slave address fields
  // ------------------------------------------------------------------
  localparam logic [3:0] DEVICE_TYPE    = 4'hA;
  localparam logic [4:0] MASTER_CODE    = 5'h01;
  localparam logic       SELECT_TOP_BIT = 1'h0;
  localparam logic       DIR_WRITE      = 1'h0;

  // ------------------------------------------------------------------
  // Bit counter and reset values
  // ------------------------------------------------------------------
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT      = 4'h9;
  localparam logic [3:0] BIT_CNT_STEP  = 4'h1;
  localparam logic [6:0] INDEX_STEP    = 7'h01;
  localparam logic [31:0] TIMER_STEP   = 32'h0000_0001;

  // ------------------------------------------------------------------
  // State types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ph_idle,
    ph_device,
    ph_addr_high,
    ph_addr_low,
    ph_data,
    ph_ignore
  } phase_t;

  typedef enum logic [1:0] {
    cs_idle,
    cs_walk,
    cs_wait
  } core_state_t;

endpackage

/* serial_eeprom_write_slave.sv */
// Two-wire EEPROM slave front end: addressing, byte and page writes, program cycle
//
// How it works
// - Selection field compared with a fixed zero bit and the two strap pins; only a match selects the device.
// - Device is slave only; master starts transfers and drives the clock.
// - Device changes data only while clock low; high-clock changes are START/STOP.
// - Bus activity is ignored until a START is seen.
// - STOP ends the transfer and enters standby once no program cycle is pending or running.
// - Two address bytes follow the slave address, upper byte first.
// - Fast mode after reset; master code after START switches to high speed.
// - STOP returns high-speed mode to fast mode.
// - Both address bytes are acknowledged; they pick one of 64K bytes.
// - Data byte acknowledged; STOP then launches the program cycle.
// - During the program cycle the device answers no request.
// - Pages are 128 aligned bytes; one page programs at once.
// - Page address increment wraps inside the page.
// - Page write may start at any offset in the page.
// - Each data byte acknowledged, counter advanced, ready for the next.
// - More than 128 bytes overwrite earlier positions via the wrapped counter.
// - Polling address not acknowledged while busy, acknowledged once done.
// - Write lock high: no ack on first data byte, no program cycle.
// - Slave address needs device type 1010 in its top four bits.
// - Address bit zero selects direction: one read, zero write.
// - Receiver drives data low during the ninth clock, then releases it.
`timescale 1ns/1ps

module serial_eeprom_write_slave #(
  parameter int unsigned PROGRAM_CYCLE_COUNT = eeprom_write_pkg::PROGRAM_CYCLES
) (
  // Core clock and reset
  input  wire logic                                  i_clock,
  input  wire logic                                  i_rst,
  // Link sampling clock
  input  wire logic                                  i_link_clock,
  // Two-wire bus pins
  input  wire logic                                  i_scl,
  input  wire logic                                  i_sda_i,
  output logic                                       o_sda_o,
  output logic                                       o_sda_oe,
  // Strap and lock pins
  input  wire logic                                  i_select_strap_high,
  input  wire logic                                  i_select_strap_low,
  input  wire logic                                  i_write_lock,
  // Link status
  output logic                                       o_high_speed,
  output logic                                       o_standby,
  // Array programming port
  output logic                                       o_busy,
  output logic                                       o_array_we,
  output logic [eeprom_write_pkg::ADDR_BITS-1:0]     o_array_addr,
  output logic [eeprom_write_pkg::DATA_BITS-1:0]     o_array_data
);
  import eeprom_write_pkg::*;

  // ------------------------------------------------------------------
  // State records
  // ------------------------------------------------------------------
  typedef struct packed {
    logic                                   scl_s1;
    logic                                   scl_s2;
    logic                                   scl_p;
    logic                                   sda_s1;
    logic                                   sda_s2;
    logic                                   sda_p;
    logic                                   lock_s1;
    logic                                   lock_s2;
    logic                                   strap_hi_s1;
    logic                                   strap_hi_s2;
    logic                                   strap_lo_s1;
    logic                                   strap_lo_s2;
    logic                                   busy_s1;
    logic                                   busy_s2;
    phase_t                                 phase;
    logic [3:0]                             bit_cnt;
    logic [7:0]                             shift;
    logic [ADDR_BITS-1:0]                   addr;
    logic [PAGE_BYTES-1:0]                  loaded;
    logic [PAGE_BYTES-1:0][DATA_BITS-1:0]   page_buf;
    logic                                   armed;
    logic                                   wait_busy;
    logic                                   start_tgl;
    logic                                   high_speed;
    logic                                   sda_oe;
    logic                                   sda_level;
    logic                                   standby;
  } link_state_t;

  typedef struct packed {
    logic                   tgl_s1;
    logic                   tgl_s2;
    logic                   tgl_p;
    core_state_t            state;
    logic [PAGE_BITS-1:0]   index;
    logic [31:0]            timer;
    logic                   busy;
    logic                   we;
    logic [ADDR_BITS-1:0]   waddr;
    logic [DATA_BITS-1:0]   wdata;
  } core_state_rec_t;

  link_state_t     link_q;
  link_state_t     link_d;
  core_state_rec_t core_q;
  core_state_rec_t core_d;

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic busy_seen;
  logic selected;
  logic ack;

  // ------------------------------------------------------------------
  // Decoding helpers
  // ------------------------------------------------------------------
  // Byte position inside its page
  function automatic logic [PAGE_BITS-1:0] page_offset(input logic [ADDR_BITS-1:0] a);
    return a[PAGE_BITS-1:0];
  endfunction

  // Aligned page number of an address
  function automatic logic [ADDR_BITS-PAGE_BITS-1:0] page_number(
    input logic [ADDR_BITS-1:0] a
  );
    return a[ADDR_BITS-1:PAGE_BITS];
  endfunction

  // Data moved while the clock stood high on two samples
  function automatic logic moved_under_high_clock(
    input logic scl_now,
    input logic scl_was,
    input logic sda_was,
    input logic sda_now
  );
    return scl_now & scl_was & (sda_was ^ sda_now);
  endfunction

  // ------------------------------------------------------------------
  // Link domain: bus decode and page loading
  // ------------------------------------------------------------------
  always_comb begin
    link_d = link_q;
    ack    = 1'b0;
    // Two-flop synchronisers for pins and the busy flag
    link_d.scl_s1      = i_scl;
    link_d.scl_s2      = link_q.scl_s1;
    link_d.scl_p       = link_q.scl_s2;
    link_d.sda_s1      = i_sda_i;
    link_d.sda_s2      = link_q.sda_s1;
    link_d.sda_p       = link_q.sda_s2;
    link_d.lock_s1     = i_write_lock;
    link_d.lock_s2     = link_q.lock_s1;
    link_d.strap_hi_s1 = i_select_strap_high;
    link_d.strap_hi_s2 = link_q.strap_hi_s1;
    link_d.strap_lo_s1 = i_select_strap_low;
    link_d.strap_lo_s2 = link_q.strap_lo_s1;
    link_d.busy_s1     = core_q.busy;
    link_d.busy_s2     = link_q.busy_s1;

    // Bus conditions and address decode
    scl        = link_q.scl_s2;
    sda        = link_q.sda_s2;
    scl_rise   = scl & ~link_q.scl_p;
    scl_fall   = ~scl & link_q.scl_p;
    start_seen = moved_under_high_clock(scl, link_q.scl_p, link_q.sda_p, sda) & ~sda;
    stop_seen  = moved_under_high_clock(scl, link_q.scl_p, link_q.sda_p, sda) & sda;
    busy_seen  = link_q.wait_busy | link_q.busy_s2;
    selected   = (link_q.shift[7:4] == DEVICE_TYPE)
               & (link_q.shift[3:1] == {SELECT_TOP_BIT, link_q.strap_hi_s2,
                                        link_q.strap_lo_s2});

    if (link_q.busy_s2) begin
      link_d.wait_busy = 1'b0;
    end
    link_d.standby   = (link_q.phase == ph_idle) & ~busy_seen;
    link_d.sda_level = 1'b0;

    // Byte framing, acknowledge slot and bus conditions
    if (start_seen) begin
      link_d.phase   = ph_device;
      link_d.bit_cnt = BIT_CNT_RESET;
      link_d.sda_oe  = 1'b0;
      link_d.armed   = 1'b0;
    end else if (stop_seen) begin
      if (link_q.armed && !busy_seen && !link_q.lock_s2) begin
        link_d.start_tgl = ~link_q.start_tgl;
        link_d.wait_busy = 1'b1;
      end
      link_d.phase      = ph_idle;
      link_d.bit_cnt    = BIT_CNT_RESET;
      link_d.sda_oe     = 1'b0;
      link_d.armed      = 1'b0;
      link_d.high_speed = 1'b0;
    end else if (link_q.phase != ph_idle) begin
      if (scl_rise && link_q.bit_cnt < BITS_PER_BYTE) begin
        link_d.shift   = {link_q.shift[6:0], sda};
        link_d.bit_cnt = link_q.bit_cnt + BIT_CNT_STEP;
      end else if (scl_fall && link_q.bit_cnt == BITS_PER_BYTE) begin
        unique case (link_q.phase)
          ph_device: begin
            if (link_q.shift[7:3] == MASTER_CODE) begin
              link_d.high_speed = 1'b1;
              link_d.phase      = ph_ignore;
            end else if (selected && !busy_seen && link_q.shift[0] == DIR_WRITE) begin
              ack          = 1'b1;
              link_d.phase = ph_addr_high;
            end else begin
              link_d.phase = ph_ignore;
            end
          end
          ph_addr_high: begin
            ack                       = 1'b1;
            link_d.addr[15:8]         = link_q.shift;
            link_d.phase              = ph_addr_low;
          end
          ph_addr_low: begin
            ack                       = 1'b1;
            link_d.addr[7:0]          = link_q.shift;
            link_d.loaded             = '0;
            link_d.phase              = ph_data;
          end
          ph_data: begin
            if (link_q.lock_s2) begin
              link_d.phase = ph_ignore;
            end else begin
              ack                                   = 1'b1;
              link_d.page_buf[page_offset(link_q.addr)] = link_q.shift;
              link_d.loaded[page_offset(link_q.addr)]   = 1'b1;
              link_d.addr[PAGE_BITS-1:0] = page_offset(link_q.addr) + INDEX_STEP;
              link_d.armed                          = 1'b1;
            end
          end
          ph_ignore: begin
            ack = 1'b0;
          end
          default: begin
            link_d.phase = ph_ignore;
          end
        endcase
        link_d.sda_oe  = ack;
        link_d.bit_cnt = ACK_SLOT;
      end else if (scl_fall && link_q.bit_cnt == ACK_SLOT) begin
        link_d.sda_oe  = 1'b0;
        link_d.bit_cnt = BIT_CNT_RESET;
      end
    end
  end

  // ------------------------------------------------------------------
  // Link domain: state register
  // ------------------------------------------------------------------
  always_ff @(posedge i_link_clock or posedge i_rst) begin
    if (i_rst) begin
      link_q            <= '0;
      link_q.scl_s1     <= 1'b1;
      link_q.scl_s2     <= 1'b1;
      link_q.scl_p      <= 1'b1;
      link_q.sda_s1     <= 1'b1;
      link_q.sda_s2     <= 1'b1;
      link_q.sda_p      <= 1'b1;
      link_q.phase      <= ph_idle;
      link_q.bit_cnt    <= BIT_CNT_RESET;
      link_q.high_speed <= 1'b0;
      link_q.standby    <= 1'b1;
    end else begin
      link_q <= link_d;
    end
  end

  // ------------------------------------------------------------------
  // Core domain: program cycle
  // ------------------------------------------------------------------
  always_comb begin
    core_d        = core_q;
    core_d.tgl_s1 = link_q.start_tgl;
    core_d.tgl_s2 = core_q.tgl_s1;
    core_d.tgl_p  = core_q.tgl_s2;
    core_d.we     = 1'b0;
    // Walk every page offset, then count the program time
    unique case (core_q.state)
      cs_idle: begin
        if (core_q.tgl_s2 != core_q.tgl_p) begin
          core_d.busy  = 1'b1;
          core_d.index = '0;
          core_d.state = cs_walk;
        end
      end
      cs_walk: begin
        if (link_q.loaded[core_q.index]) begin
          core_d.we    = 1'b1;
          core_d.waddr = {page_number(link_q.addr), core_q.index};
          core_d.wdata = link_q.page_buf[core_q.index];
        end
        core_d.index = core_q.index + INDEX_STEP;
        if (core_q.index == PAGE_LAST) begin
          core_d.timer = '0;
          core_d.state = cs_wait;
        end
      end
      cs_wait: begin
        core_d.timer = core_q.timer + TIMER_STEP;
        if (core_q.timer >= PROGRAM_CYCLE_COUNT - 1) begin
          core_d.busy  = 1'b0;
          core_d.state = cs_idle;
        end
      end
      default: begin
        core_d.busy  = 1'b0;
        core_d.state = cs_idle;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // Core domain: state register
  // ------------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      core_q       <= '0;
      core_q.state <= cs_idle;
    end else begin
      core_q <= core_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign o_sda_o      = link_q.sda_level;
  assign o_sda_oe     = link_q.sda_oe;
  assign o_high_speed = link_q.high_speed;
  assign o_standby    = link_q.standby;
  assign o_busy       = core_q.busy;
  assign o_array_we   = core_q.we;
  assign o_array_addr = core_q.waddr;
  assign o_array_data = core_q.wdata;

endmodule

/* serial_eeprom_write_slave_assertions.sv */
// Concurrent checks on the ports of the two-wire EEPROM write front end
`timescale 1ns/1ps

module serial_eeprom_write_slave_assertions (
  // Clocks and reset
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic        i_link_clock,
  // Bus and status
  input wire logic        i_scl,
  input wire logic        o_sda_o,
  input wire logic        o_sda_oe,
  input wire logic        o_high_speed,
  input wire logic        o_standby,
  input wire logic        o_busy,
  input wire logic        o_array_we,
  input wire logic [15:0] o_array_addr
);
  // ------------------------------------------------------------------
  // Link domain
  // ------------------------------------------------------------------
  ack_drive_low_a: assert property (@(posedge i_link_clock) disable iff (i_rst)
    o_sda_oe |-> !o_sda_o) else $error("ack drives data high");
  ack_scl_low_a: assert property (@(posedge i_link_clock) disable iff (i_rst)
    $rose(o_sda_oe) |-> !i_scl) else $error("ack starts while clock high");
  ack_release_a: assert property (@(posedge i_link_clock) disable iff (i_rst)
    $fell(o_sda_oe) |-> !i_scl) else $error("ack ends while clock high");
  ack_hold_a: assert property (@(posedge i_link_clock) disable iff (i_rst)
    $rose(o_sda_oe) |-> o_sda_oe[*8]) else $error("ack too short");
  code_nack_a: assert property (@(posedge i_link_clock) disable iff (i_rst)
    $rose(o_high_speed) |-> (!o_sda_oe)[*8]) else $error("master code acked");
  // ------------------------------------------------------------------
  // Core domain
  // ------------------------------------------------------------------
  busy_quiet_a: assert property (@(posedge i_clock) disable iff (i_rst)
    o_busy |-> !o_sda_oe) else $error("ack while busy");
  we_in_busy_a: assert property (@(posedge i_clock) disable iff (i_rst)
    o_array_we |-> o_busy) else $error("array write outside program cycle");
  we_order_a: assert property (@(posedge i_clock) disable iff (i_rst)
    o_array_we ##1 o_array_we |-> o_array_addr[15:7] == $past(o_array_addr[15:7])
      && o_array_addr[6:0] > $past(o_array_addr[6:0])) else $error("array write order");
  busy_standby_a: assert property (@(posedge i_clock) disable iff (i_rst)
    o_busy |-> !o_standby) else $error("standby while busy");
endmodule

bind serial_eeprom_write_slave serial_eeprom_write_slave_assertions i_chk (
  .i_clock(i_clock), .i_rst(i_rst), .i_link_clock(i_link_clock), .i_scl(i_scl),
  .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_high_speed(o_high_speed),
  .o_standby(o_standby), .o_busy(o_busy), .o_array_we(o_array_we),
  .o_array_addr(o_array_addr));

/* test_serial_eeprom_write_slave.sv */
// Self-checking bench for the two-wire EEPROM write front end
`timescale 1ns/1ps

module test_serial_eeprom_write_slave;
  import eeprom_write_pkg::*;
  localparam int PCC = 1000;
  logic        i_clock = 1'b0;
  logic        i_link_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_select_strap_high = 1'b1;
  logic        i_select_strap_low = 1'b0;
  logic        i_write_lock = 1'b0;
  logic        scl, m_oe, sda, o_sda_o, o_sda_oe, o_high_speed, o_standby, o_busy, o_array_we;
  logic [15:0] o_array_addr;
  logic [7:0]  o_array_data;
  logic [23:0] wq[$];
  int          bad_count = 0;
  int          tests_run = 0;

  always #25 i_clock = ~i_clock;
  initial begin
    #13;
    forever #62.5 i_link_clock = ~i_link_clock;
  end
  assign sda = m_oe ? 1'b0 : (o_sda_oe ? o_sda_o : 1'b1);
  always @(posedge i_clock) if (o_array_we === 1'b1) wq.push_back({o_array_addr, o_array_data});

  bus_master_model i_m (.i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));
  serial_eeprom_write_slave #(.PROGRAM_CYCLE_COUNT(PCC)) i_dut (
    .i_clock(i_clock), .i_rst(i_rst), .i_link_clock(i_link_clock), .i_scl(scl),
    .i_sda_i(sda), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe),
    .i_select_strap_high(i_select_strap_high), .i_select_strap_low(i_select_strap_low),
    .i_write_lock(i_write_lock), .o_high_speed(o_high_speed), .o_standby(o_standby),
    .o_busy(o_busy), .o_array_we(o_array_we), .o_array_addr(o_array_addr),
    .o_array_data(o_array_data));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic [7:0] b, input logic exp_ack, input string what);
    logic ack;
    i_m.send_byte(b, ack);
    check(what, 24'(exp_ack), 24'(ack));
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (o_busy !== lvl) begin
      @(posedge i_clock);
      n++;
      if (n > lim) begin
        $display("Error busy wait expected %b seen timeout", lvl);
        bad_count++;
        tally_and_finish();
      end
    end
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_byte_poll();
    i_m.start();
    xfer(8'hA4, 1'b1, "select");
    xfer(8'h12, 1'b1, "addr high");
    xfer(8'h34, 1'b1, "addr low");
    xfer(8'h5A, 1'b1, "data");
    check("active", 24'h0, 24'(o_standby));
    i_m.stop();
    i_m.start();
    xfer(8'hA4, 1'b0, "poll busy");
    i_m.stop();
    wait_busy(1'b0, PCC + 400);
    i_m.start();
    xfer(8'hA4, 1'b1, "poll done");
    i_m.stop();
    check("byte count", 24'h1, 24'(wq.size()));
    check("byte write", 24'h12345A, wq[0]);
    wq.delete();
    $display("byte write and polling done");
  endtask
  task automatic t_page();
    logic [7:0] exp[128];
    i_m.start();
    xfer(8'hA4, 1'b1, "select");
    xfer(8'h0A, 1'b1, "addr high");
    xfer(8'h7E, 1'b1, "addr low");
    for (int k = 0; k < 130; k++) begin
      xfer(8'(k), 1'b1, "page data");
      exp[7'(k + 32'h7E)] = 8'(k);
    end
    i_m.stop();
    wait_busy(1'b1, 400);
    wait_busy(1'b0, PCC + 400);
    check("page count", 24'h80, 24'(wq.size()));
    for (int i = 0; i < 128; i++) check("page byte", {16'h0A00 + 16'(i), exp[i]}, wq[i]);
    wq.delete();
    $display("page write done");
  endtask
  task automatic t_refuse();
    logic [7:0] bad[4] = '{8'hB4, 8'hA6, 8'hAC, 8'hA5};
    for (int i = 0; i < 4; i++) begin
      i_m.start();
      xfer(bad[i], 1'b0, "refused");
      xfer(8'h00, 1'b0, "ignored");
      i_m.stop();
    end
    check("refused writes", 24'h0, 24'(wq.size()));
    $display("refused addresses done");
  endtask
  task automatic t_lock();
    @(posedge i_clock) #1;
    i_write_lock = 1'b1;
    i_select_strap_high = 1'b0;
    i_select_strap_low = 1'b1;
    i_m.start();
    xfer(8'hA2, 1'b1, "select");
    xfer(8'h00, 1'b1, "addr high");
    xfer(8'h10, 1'b1, "addr low");
    xfer(8'h77, 1'b0, "locked data");
    i_m.stop();
    repeat (20) @(posedge i_clock);
    #1;
    check("lock busy", 24'h0, 24'(o_busy));
    check("lock writes", 24'h0, 24'(wq.size()));
    i_write_lock = 1'b0;
    i_m.start();
    xfer(8'hA2, 1'b1, "select");
    xfer(8'h00, 1'b1, "addr high");
    xfer(8'h20, 1'b1, "addr low");
    xfer(8'h66, 1'b1, "data before lock");
    @(posedge i_clock) #1;
    i_write_lock = 1'b1;
    xfer(8'h67, 1'b0, "data after lock");
    i_m.stop();
    repeat (20) @(posedge i_clock);
    #1;
    check("late lock busy", 24'h0, 24'(o_busy));
    check("late lock writes", 24'h0, 24'(wq.size()));
    i_write_lock = 1'b0;
    $display("write lock done");
  endtask
  task automatic t_hs();
    i_m.start();
    xfer(8'h09, 1'b0, "master code");
    check("high speed", 24'h1, 24'(o_high_speed));
    i_m.stop();
    check("fast after stop", 24'h0, 24'(o_high_speed));
    check("standby", 24'h1, 24'(o_standby));
    $display("speed mode done");
  endtask

  initial begin
    repeat (12) @(posedge i_clock);
    #1 i_rst = 1'b0;
    check("reset fast", 24'h0, 24'(o_high_speed));
    check("reset busy", 24'h0, 24'(o_busy));
    repeat (10) @(posedge i_clock);
    t_byte_poll();
    t_page();
    t_refuse();
    t_lock();
    t_hs();
    tally_and_finish();
  end
endmodule
